// ===== rtl/mdr_pkg.sv
// Purpose: shared constants and types of the meter display register set
// Assumes: 5-bit register select, 16-bit register data
// Notes: variant figures are picked by the top-level parameter
package mdr_pkg;

  // register select codes
  localparam logic [4:0] MDR_ADDR_UNDER_LIMIT = 5'h05;
  localparam logic [4:0] MDR_ADDR_SEG_LOW = 5'h06;
  localparam logic [4:0] MDR_ADDR_SEG_MID = 5'h07;
  localparam logic [4:0] MDR_ADDR_SEG_HIGH = 5'h08;
  localparam logic [4:0] MDR_ADDR_USER_OFFSET = 5'h09;
  localparam logic [4:0] MDR_ADDR_RESULT_HIGH = 5'h0a;
  localparam logic [4:0] MDR_ADDR_DISPLAY_VALUE = 5'h0b;

  // reset values
  localparam logic [15:0] MDR_RST_UNDER_3P5 = 16'h8300;
  localparam logic [15:0] MDR_RST_UNDER_4P5 = 16'hb1e0;
  localparam logic [14:0] MDR_RST_SEG_LOW = 15'h0000;
  localparam logic [14:0] MDR_RST_SEG_MID = 15'h0000;
  localparam logic [7:0] MDR_RST_SEG_HIGH = 8'h00;
  localparam logic [15:0] MDR_RST_USER_OFFSET = 16'h0000;
  localparam logic [15:0] MDR_RST_RESULT = 16'h0000;
  localparam logic [15:0] MDR_RST_DISPLAY = 16'h0000;

  // field positions inside the segment registers
  localparam int MDR_SEG_LOW_LSB = 1;
  localparam int MDR_SEG_MID_LSB = 1;
  localparam int MDR_SEGH_PEAK = 7;
  localparam int MDR_SEGH_HOLD = 6;
  localparam int MDR_SEGH_LEAD_ONE = 5;
  localparam int MDR_SEGH_DIG4_MSB = 4;
  // digit-4 f, e, dp sit at bits 15..13 of the mid register (index 14..12 of stored bits)
  localparam int MDR_SEGM_DIG4_MSB = 14;
  localparam int MDR_SEGM_DIG4_LSB = 12;

  // 3.5-digit result keeps 12 bits, low 4 bits are sub-bits
  localparam int MDR_SHORT_SUB_BITS = 4;

  // display source, in falling priority
  typedef enum logic [2:0] {
    MDR_SRC_SEGMENT = 3'b000,
    MDR_SRC_HOST = 3'b001,
    MDR_SRC_HOLD = 3'b010,
    MDR_SRC_PEAK = 3'b011,
    MDR_SRC_LIVE = 3'b100
  } mdr_src_t;

endpackage

// ===== rtl/mdr_seg_if.sv
// Purpose: carries the segment override bits from the register file to the segment mapper
// Assumes: stored bits exclude the always-zero bit 0 of the 16-bit registers
// Notes: regs side drives, map side reads
`timescale 1ns/1ps
interface mdr_seg_if;
  logic [14:0] seg_low;
  logic [14:0] seg_mid;
  logic [7:0] seg_high;
  logic override_on;
  modport regs (output seg_low, output seg_mid, output seg_high, output override_on);
  modport map (input seg_low, input seg_mid, input seg_high, input override_on);
endinterface

// ===== rtl/mdr_seg_map.sv
// Purpose: turns active-low override bits into lit-segment drive levels
// Assumes: one variant fixed at elaboration
// Notes: outputs are registered, all dark while override is off
`timescale 1ns/1ps
module mdr_seg_map
  import mdr_pkg::*;
#(
  parameter bit FOUR_HALF = 1'b1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // override bits
  mdr_seg_if.map seg,
  // lit levels, 1 lights the segment
  output logic [14:0] o_lit_low,
  output logic [14:0] o_lit_mid,
  output logic [7:0] o_lit_high,
  output logic o_lead_one_pos5,
  output logic o_lead_one_pos4
);

  logic [14:0] mid_lit;
  logic [7:0] high_lit;

  // RL5 active-low inversion
  // RL9 digit-4 masked on short variant
  always_comb begin
    mid_lit = ~seg.seg_mid;
    high_lit = ~seg.seg_high;
    if (!FOUR_HALF) begin
      mid_lit[MDR_SEGM_DIG4_MSB:MDR_SEGM_DIG4_LSB] = 3'h0;
      high_lit[MDR_SEGH_DIG4_MSB:0] = 5'h00;
    end
  end

  // RL4 drive segments directly
  // RL10 leading one position
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_lit_low <= 15'h0000;
      o_lit_mid <= 15'h0000;
      o_lit_high <= 8'h00;
      o_lead_one_pos5 <= 1'b0;
      o_lead_one_pos4 <= 1'b0;
    end else if (seg.override_on) begin
      o_lit_low <= ~seg.seg_low;
      o_lit_mid <= mid_lit;
      o_lit_high <= high_lit;
      o_lead_one_pos5 <= FOUR_HALF & high_lit[MDR_SEGH_LEAD_ONE];
      o_lead_one_pos4 <= !FOUR_HALF & high_lit[MDR_SEGH_LEAD_ONE];
    end else begin
      o_lit_low <= 15'h0000;
      o_lit_mid <= 15'h0000;
      o_lit_high <= 8'h00;
      o_lead_one_pos5 <= 1'b0;
      o_lead_one_pos4 <= 1'b0;
    end
  end

endmodule

// ===== rtl/mdr_regs.sv
// Purpose: register set of a panel-meter converter with segment display driver
// Assumes: command framing outside decodes reads, writes and status reads into strobes
// Notes: conversion words arrive already auto-calibrated, 16 most significant bits
//
// Summary of operation
// RL1 - 16-bit underrange limit, flag when result below
// RL2 - underrange shows minus one and dashes
// RL3 - limit resets to minus full-scale pattern
// RL4 - override select drives segments from registers
// RL5 - override bits low light, high blank
// RL6 - first segment register bit layout, bit0 zero
// RL7 - second segment register bit layout, bit0 zero
// RL8 - third segment register, eight bits layout
// RL9 - digit-4 bits dark on short variant
// RL10 - leading one lights position five or four
// RL11 - segment registers reset to all lit
// RL12 - user offset subtracted from every conversion
// RL13 - read-only result register, resets zero
// RL14 - short variant result twelve bits, low zero
// RL15 - display data loaded by source selection
// RL16 - display data two's complement, variant widths
// RL17 - display source priority order
// RL18 - underrange flag sticky, cleared by status read
// RL19 - host loads segments before setting select
// RL20 - signed compare once per conversion
`timescale 1ns/1ps
module mdr_regs
  import mdr_pkg::*;
#(
  parameter bit FOUR_HALF = 1'b1,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // register port from the command framing
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [4:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // status register read strobe
  input wire logic i_status_rd,
  // control bits held in the control register outside
  input wire logic i_segment_override_select,
  input wire logic i_display_select,
  input wire logic i_hold,
  input wire logic i_peak,
  // conversion path
  input wire logic i_conv_valid,
  input wire logic [15:0] i_conv_raw,
  input wire logic [15:0] i_peak_value,
  // status and display
  output logic o_underrange_flag,
  output logic o_under_display,
  output logic [2:0] o_display_source,
  output logic [15:0] o_display_value,
  output logic [15:0] o_result_high,
  output logic o_result_update,
  // segment drive, 1 lights
  output logic [14:0] o_lit_low,
  output logic [14:0] o_lit_mid,
  output logic [7:0] o_lit_high,
  output logic o_lead_one_pos5,
  output logic o_lead_one_pos4
);

  // elaboration check: the register map is fixed at 16 bits
  if (DATA_W != 16) begin : g_bad_width
    $error("mdr_regs supports DATA_W of 16 only");
  end

  // RL3 reset pattern per variant
  localparam logic [15:0] UNDER_RST = FOUR_HALF ? MDR_RST_UNDER_4P5 : MDR_RST_UNDER_3P5;

  // stored registers
  logic [15:0] under_limit_q;
  logic [14:0] seg_low_q;
  logic [14:0] seg_mid_q;
  logic [7:0] seg_high_q;
  logic [15:0] user_offset_q;
  logic [15:0] result_q;
  logic [15:0] display_q;

  // status and helper state
  logic under_flag_q;
  logic under_now_q;
  logic result_update_q;
  logic [15:0] rdata_q;
  logic rvalid_q;

  // decoded strobes and next values
  logic wr_under;
  logic wr_seg_low;
  logic wr_seg_mid;
  logic wr_seg_high;
  logic wr_offset;
  logic wr_display;
  logic [15:0] final_d;
  logic below_d;
  mdr_src_t src_d;

  mdr_seg_if seg_bus ();

  // write decode, read-only result ignores writes
  always_comb begin
    wr_under = i_reg_wr && (i_reg_addr == MDR_ADDR_UNDER_LIMIT);
    wr_seg_low = i_reg_wr && (i_reg_addr == MDR_ADDR_SEG_LOW);
    wr_seg_mid = i_reg_wr && (i_reg_addr == MDR_ADDR_SEG_MID);
    wr_seg_high = i_reg_wr && (i_reg_addr == MDR_ADDR_SEG_HIGH);
    wr_offset = i_reg_wr && (i_reg_addr == MDR_ADDR_USER_OFFSET);
    wr_display = i_reg_wr && (i_reg_addr == MDR_ADDR_DISPLAY_VALUE);
  end

  // RL17 display source priority
  always_comb begin
    if (i_segment_override_select) begin
      src_d = MDR_SRC_SEGMENT;
    end else if (i_display_select) begin
      src_d = MDR_SRC_HOST;
    end else if (i_hold) begin
      src_d = MDR_SRC_HOLD;
    end else if (i_peak) begin
      src_d = MDR_SRC_PEAK;
    end else begin
      src_d = MDR_SRC_LIVE;
    end
  end

  // RL12 offset subtraction
  // RL14 short variant drops sub-bits
  always_comb begin
    final_d = i_conv_raw - user_offset_q;
    if (!FOUR_HALF) begin
      final_d[MDR_SHORT_SUB_BITS-1:0] = 4'h0;
    end
  end

  // RL20 signed compare against limit
  assign below_d = $signed(final_d) < $signed(under_limit_q);

  // RL1 underrange limit storage
  // RL3 resets to minus full scale
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      under_limit_q <= UNDER_RST;
    end else if (wr_under) begin
      under_limit_q <= i_reg_wdata;
    end
  end

  // RL6 first register, bit 0 dropped
  // RL7 second register, bit 0 dropped
  // RL8 third register, eight bits
  // RL11 all segments reset lit
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seg_low_q <= MDR_RST_SEG_LOW;
      seg_mid_q <= MDR_RST_SEG_MID;
      seg_high_q <= MDR_RST_SEG_HIGH;
    end else begin
      if (wr_seg_low) begin
        seg_low_q <= i_reg_wdata[15:MDR_SEG_LOW_LSB];
      end
      if (wr_seg_mid) begin
        seg_mid_q <= i_reg_wdata[15:MDR_SEG_MID_LSB];
      end
      if (wr_seg_high) begin
        seg_high_q <= i_reg_wdata[7:0];
      end
    end
  end

  // RL12 user offset storage
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      user_offset_q <= MDR_RST_USER_OFFSET;
    end else if (wr_offset) begin
      user_offset_q <= i_reg_wdata;
    end
  end

  // RL13 result captured per conversion
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      result_q <= MDR_RST_RESULT;
      result_update_q <= 1'b0;
    end else begin
      result_update_q <= i_conv_valid;
      if (i_conv_valid) begin
        result_q <= final_d;
      end
    end
  end

  // RL20 condition held per conversion
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      under_now_q <= 1'b0;
    end else if (i_conv_valid) begin
      under_now_q <= below_d;
    end
  end

  // RL18 sticky flag, set wins
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      under_flag_q <= 1'b0;
    end else if (i_conv_valid && below_d) begin
      under_flag_q <= 1'b1;
    end else if (i_status_rd) begin
      under_flag_q <= under_now_q;
    end
  end

  // RL15 display data loading
  // RL16 two's complement passes unchanged
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      display_q <= MDR_RST_DISPLAY;
    end else begin
      case (src_d)
        MDR_SRC_PEAK: begin
          display_q <= i_peak_value;
        end
        MDR_SRC_LIVE: begin
          if (i_conv_valid) begin
            display_q <= final_d;
          end else if (wr_display) begin
            display_q <= i_reg_wdata;
          end
        end
        MDR_SRC_SEGMENT, MDR_SRC_HOST, MDR_SRC_HOLD: begin
          if (wr_display) begin
            display_q <= i_reg_wdata;
          end
        end
        default: begin
          display_q <= display_q;
        end
      endcase
    end
  end

  // register read path, one cycle latency, unmapped reads zero
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          MDR_ADDR_UNDER_LIMIT: begin
            rdata_q <= under_limit_q;
          end
          // RL6 bit 0 reads zero
          MDR_ADDR_SEG_LOW: begin
            rdata_q <= {seg_low_q, 1'b0};
          end
          // RL7 bit 0 reads zero
          MDR_ADDR_SEG_MID: begin
            rdata_q <= {seg_mid_q, 1'b0};
          end
          MDR_ADDR_SEG_HIGH: begin
            rdata_q <= {8'h00, seg_high_q};
          end
          MDR_ADDR_USER_OFFSET: begin
            rdata_q <= user_offset_q;
          end
          MDR_ADDR_RESULT_HIGH: begin
            rdata_q <= result_q;
          end
          MDR_ADDR_DISPLAY_VALUE: begin
            rdata_q <= display_q;
          end
          default: begin
            rdata_q <= 16'h0000;
          end
        endcase
      end
    end
  end

  // RL19 override select is a plain level; host orders its writes
  assign seg_bus.seg_low = seg_low_q;
  assign seg_bus.seg_mid = seg_mid_q;
  assign seg_bus.seg_high = seg_high_q;
  assign seg_bus.override_on = i_segment_override_select;

  // segment mapping per variant
  mdr_seg_map #(
    .FOUR_HALF(FOUR_HALF)
  ) u_seg_map (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .seg(seg_bus),
    .o_lit_low(o_lit_low),
    .o_lit_mid(o_lit_mid),
    .o_lit_high(o_lit_high),
    .o_lead_one_pos5(o_lead_one_pos5),
    .o_lead_one_pos4(o_lead_one_pos4)
  );

  // RL2 minus one and dashes request, numeric modes only
  assign o_under_display = under_now_q && (src_d != MDR_SRC_SEGMENT);

  // outputs
  assign o_underrange_flag = under_flag_q;
  assign o_display_source = src_d;
  assign o_display_value = display_q;
  assign o_result_high = result_q;
  assign o_result_update = result_update_q;
  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;

endmodule

// ===== verif/mdr_regs_checker.sv
// Purpose: port checks of the meter display register set
// Assumes: one clock domain, select codes from the package
// Notes: bound onto every mdr_regs instance
`timescale 1ns/1ps
module mdr_regs_checker
  import mdr_pkg::*;
#(
  parameter bit FOUR_HALF = 1'b1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [4:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // control and conversion
  input wire logic i_status_rd,
  input wire logic i_segment_override_select,
  input wire logic i_display_select,
  input wire logic i_hold,
  input wire logic i_peak,
  input wire logic i_conv_valid,
  // results
  input wire logic o_underrange_flag,
  input wire logic o_result_update,
  input wire logic [2:0] o_display_source,
  input wire logic [14:0] o_lit_low,
  input wire logic [7:0] o_lit_high
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // read of one select code
  sequence s_rd(a);
    i_reg_rd && i_reg_addr == a;
  endsequence
  // top segment word written, then override held two cycles
  sequence s_seg_shown;
    (i_reg_wr && i_reg_addr == MDR_ADDR_SEG_HIGH) ##1 (i_segment_override_select && !i_reg_wr)[*2];
  endsequence
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray read valid");
  a_unmapped_zero: assert property (s_rd(5'h1f) |=> o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_seg_bit0: assert property ((s_rd(MDR_ADDR_SEG_LOW) or s_rd(MDR_ADDR_SEG_MID)) |=> !o_reg_rdata[0])
    else $error("segment bit 0 not zero");
  a_seg_high_width: assert property (s_rd(MDR_ADDR_SEG_HIGH) |=> o_reg_rdata[15:8] == 8'h00)
    else $error("top segment word wider than 8");
  a_update_pulse: assert property (o_result_update == $past(i_conv_valid))
    else $error("result update not one cycle after conversion");
  a_src_priority: assert property (o_display_source == (i_segment_override_select ? 3'h0 :
    i_display_select ? 3'h1 : i_hold ? 3'h2 : i_peak ? 3'h3 : 3'h4)) else $error("display source order");
  a_dark_off: assert property (!$past(i_segment_override_select) |-> o_lit_low == 15'h0000 &&
    o_lit_high == 8'h00) else $error("segments lit without override");
  a_seg_active_low: assert property (s_seg_shown |->
    o_lit_high == (~$past(i_reg_wdata[7:0], 2) & (FOUR_HALF ? 8'hff : 8'he0)))
    else $error("override bits not active low");
  a_flag_sticky: assert property (o_underrange_flag && !i_status_rd |=> o_underrange_flag)
    else $error("flag dropped without status read");
  a_flag_cause: assert property ($rose(o_underrange_flag) |-> $past(i_conv_valid))
    else $error("flag rose without conversion");
endmodule
bind mdr_regs mdr_regs_checker #(.FOUR_HALF(FOUR_HALF)) u_chk (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .i_status_rd(i_status_rd), .i_segment_override_select(i_segment_override_select),
  .i_display_select(i_display_select), .i_hold(i_hold), .i_peak(i_peak), .i_conv_valid(i_conv_valid),
  .o_underrange_flag(o_underrange_flag), .o_result_update(o_result_update),
  .o_display_source(o_display_source), .o_lit_low(o_lit_low), .o_lit_high(o_lit_high)
);

// ===== verif/mdr_host.sv
// Purpose: host model driving the register strobes
// Assumes: one access per strobe cycle
// Notes: released bus shows inverted values
`timescale 1ns/1ps
module mdr_host
  import mdr_pkg::*;
(
  // clock
  input wire logic i_clk_sys,
  // register strobes
  output logic o_wr,
  output logic o_rd,
  output logic [4:0] o_addr,
  output logic [15:0] o_wdata,
  // override select bit
  output logic o_segment_override_select
);
  int gap = 0; // idle cycles before an access, slow host
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 5'h00;
    o_wdata = 16'h0000;
    o_segment_override_select = 1'b0;
  end
  // one strobe cycle, then release
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    repeat (gap) @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    #1;
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk_sys);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic seg_show(input logic [15:0] lo, input logic [15:0] mid, input logic [7:0] hi);
    acc(1'b1, MDR_ADDR_SEG_LOW, lo);
    acc(1'b1, MDR_ADDR_SEG_MID, mid);
    acc(1'b1, MDR_ADDR_SEG_HIGH, {8'h00, hi});
    o_segment_override_select = 1'b1;
  endtask
endmodule

// ===== verif/mdr_regs_tb.sv
// Purpose: self-checking bench of the meter display register set
// Assumes: 4.5-digit build, with a 3.5-digit build beside it on the same inputs
// Notes: reads queue expectations, a monitor compares
`timescale 1ns/1ps
module mdr_regs_tb;
  import mdr_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_reg_wr, i_reg_rd, i_segment_override_select, o_reg_rvalid, o_underrange_flag, o_under_display;
  logic [4:0] i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, o_display_value, o_result_high, r, off, v;
  logic i_status_rd = 1'b0, i_display_select = 1'b0, i_hold = 1'b0, i_peak = 1'b0, i_conv_valid = 1'b0;
  logic [15:0] i_conv_raw = 16'h0000, i_peak_value = 16'h0000;
  logic [2:0] o_display_source;
  logic [14:0] o_lit_low, o_lit_mid;
  logic [7:0] o_lit_high;
  // short variant outputs and override words
  logic [15:0] lo, md, s_rdata, s_result_high, s_display_value;
  logic [14:0] s_lit_mid;
  logic [7:0] s_lit_high;
  logic s_pos5, s_pos4, o_lead_one_pos5, o_lead_one_pos4;
  logic [15:0] exp_q[$];
  int errors = 0, comparisons = 0, cycles = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  mdr_host h (.i_clk_sys(i_clk_sys), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
    .o_wdata(i_reg_wdata), .o_segment_override_select(i_segment_override_select));
  mdr_regs #(.FOUR_HALF(1'b1), .DATA_W(16)) uut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_status_rd(i_status_rd),
    .i_segment_override_select(i_segment_override_select), .i_display_select(i_display_select),
    .i_hold(i_hold), .i_peak(i_peak), .i_conv_valid(i_conv_valid), .i_conv_raw(i_conv_raw),
    .i_peak_value(i_peak_value), .o_underrange_flag(o_underrange_flag), .o_under_display(o_under_display),
    .o_display_source(o_display_source), .o_display_value(o_display_value), .o_result_high(o_result_high),
    .o_result_update(), .o_lit_low(o_lit_low), .o_lit_mid(o_lit_mid), .o_lit_high(o_lit_high),
    .o_lead_one_pos5(o_lead_one_pos5), .o_lead_one_pos4(o_lead_one_pos4));
  // short variant sees the same inputs
  mdr_regs #(.FOUR_HALF(1'b0), .DATA_W(16)) uut_short (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(s_rdata), .o_reg_rvalid(), .i_status_rd(i_status_rd),
    .i_segment_override_select(i_segment_override_select), .i_display_select(i_display_select),
    .i_hold(i_hold), .i_peak(i_peak), .i_conv_valid(i_conv_valid), .i_conv_raw(i_conv_raw),
    .i_peak_value(i_peak_value), .o_underrange_flag(), .o_under_display(),
    .o_display_source(), .o_display_value(s_display_value), .o_result_high(s_result_high),
    .o_result_update(), .o_lit_low(), .o_lit_mid(s_lit_mid), .o_lit_high(s_lit_high),
    .o_lead_one_pos5(s_pos5), .o_lead_one_pos4(s_pos4));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    h.acc(1'b0, a, 16'h0000);
  endtask
  // conversion pulse, raw word then inverted
  task automatic conv(input logic [15:0] raw);
    @(posedge i_clk_sys);
    #1;
    i_conv_valid = 1'b1;
    i_conv_raw = raw;
    @(posedge i_clk_sys);
    #1;
    i_conv_valid = 1'b0;
    i_conv_raw = ~raw;
  endtask
  task close_out;
    if (exp_q.size() != 0) begin
      errors++;
    end
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // read data monitor, oldest note first
  always @(negedge i_clk_sys) begin
    if (o_reg_rvalid === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk(o_reg_rdata, exp_q.pop_front());
      end else begin
        chk(o_reg_rdata, ~o_reg_rdata);
      end
    end
  end
  // hang guard
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    r = 16'($urandom(83));
    repeat (16) @(posedge i_clk_sys);
    #1;
    i_arst_n = 1'b1;
    // reset values, unmapped place
    for (int a = 5; a <= 11; a++) rd(a[4:0], (a == 5) ? MDR_RST_UNDER_4P5 : 16'h0000);
    rd(5'h1f, 16'h0000);
    rd(MDR_ADDR_UNDER_LIMIT, MDR_RST_UNDER_4P5);
    chk(s_rdata, MDR_RST_UNDER_3P5);
    // reset segment words light every segment, except digit 4 on the short build
    h.o_segment_override_select = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk({1'b0, o_lit_low}, 16'h7fff);
    chk({o_lit_high, s_lit_high}, 16'hffe0);
    h.o_segment_override_select = 1'b0;
    // write then read back every place
    for (int a = 5; a <= 11; a++) begin
      r = 16'($urandom);
      h.acc(1'b1, a[4:0], r);
      rd(a[4:0], a == 10 ? 16'h0000 : a == 8 ? {8'h00, r[7:0]} : (a == 6 || a == 7) ? {r[15:1], 1'b0} : r);
    end
    off = 16'($urandom);
    v = 16'($urandom);
    h.acc(1'b1, MDR_ADDR_USER_OFFSET, off);
    h.acc(1'b1, MDR_ADDR_UNDER_LIMIT, 16'h8000);
    conv(v);
    rd(MDR_ADDR_RESULT_HIGH, v - off);
    rd(MDR_ADDR_DISPLAY_VALUE, v - off);
    chk({15'h0000, o_underrange_flag}, 16'h0000);
    h.acc(1'b1, MDR_ADDR_UNDER_LIMIT, 16'h0000);
    conv(off - 16'h0001);
    chk(o_result_high, 16'hffff);
    chk(s_result_high, 16'hfff0);
    chk(s_display_value, 16'hfff0);
    rd(MDR_ADDR_RESULT_HIGH, 16'hffff);
    chk({15'h0000, o_underrange_flag}, 16'h0001);
    chk({15'h0000, o_under_display}, 16'h0001);
    conv(off + 16'h0005);
    rd(MDR_ADDR_RESULT_HIGH, 16'h0005);
    chk({15'h0000, o_underrange_flag}, 16'h0001);
    @(posedge i_clk_sys);
    #1;
    i_status_rd = 1'b1;
    @(posedge i_clk_sys);
    #1;
    i_status_rd = 1'b0;
    @(posedge i_clk_sys);
    #1;
    chk({15'h0000, o_underrange_flag}, 16'h0000);
    // hold, peak and host sources, slow host
    h.gap = 2;
    i_hold = 1'b1;
    conv(16'($urandom));
    rd(MDR_ADDR_DISPLAY_VALUE, 16'h0005);
    i_hold = 1'b0;
    i_peak = 1'b1;
    i_peak_value = 16'($urandom);
    rd(MDR_ADDR_DISPLAY_VALUE, i_peak_value);
    i_peak = 1'b0;
    i_display_select = 1'b1;
    r = 16'($urandom);
    h.acc(1'b1, MDR_ADDR_DISPLAY_VALUE, r);
    conv(16'($urandom));
    rd(MDR_ADDR_DISPLAY_VALUE, r);
    chk(o_display_value, r);
    i_display_select = 1'b0;
    // override drive from segment words
    r = 16'($urandom);
    lo = 16'($urandom);
    md = 16'($urandom);
    h.seg_show(lo, md, r[7:0]);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk({8'h00, o_lit_high}, {8'h00, ~r[7:0]});
    chk({1'b0, o_lit_low}, {1'b0, ~lo[15:1]});
    chk({1'b0, o_lit_mid}, {1'b0, ~md[15:1]});
    chk({1'b0, s_lit_mid}, {4'h0, ~md[12:1]});
    chk({8'h00, s_lit_high}, {8'h00, ~r[7:5], 5'h00});
    chk({14'h0000, o_lead_one_pos5, o_lead_one_pos4}, {14'h0000, ~r[5], 1'b0});
    chk({14'h0000, s_pos5, s_pos4}, {14'h0000, 1'b0, ~r[5]});
    h.o_segment_override_select = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    close_out();
  end
endmodule
